// *** bip_ext_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// far-side circuit model
module bip_ext_model (
  input wire logic aclk,
  input wire logic [7:0] data_out,
  input wire logic oe_n,
  input wire logic ack_n,
  output logic [7:0] data_in,
  output var logic out_en,
  output var logic strobe,
  output var logic bypass,
  output var logic req_n,
  output var logic flag_n
);
  logic [7:0] drv;
  logic drv_on;
  // released lines show drv while drv_on, else its inverse, so stale data never passes
  assign data_in = !oe_n ? data_out : (drv_on ? drv : ~drv);
  initial begin
    out_en = 1'b0;
    strobe = 1'b0;
    bypass = 1'b1;
    req_n = 1'b1;
    flag_n = 1'b1;
    drv = 8'h00;
    drv_on = 1'b0;
  end
  task automatic set_pins(input logic en, input logic byp, input logic fl);
    @(posedge aclk);
    out_en <= en;
    bypass <= byp;
    flag_n <= fl;
    if (en) begin
      drv_on <= 1'b0;
    end
  endtask
  // three-cycle gaps cover the device's two-flop input sampling
  task automatic send_byte(input logic [7:0] b, input logic pulse);
    @(posedge aclk);
    out_en <= 1'b0;
    repeat (3) @(posedge aclk);
    drv <= b;
    drv_on <= 1'b1;
    repeat (3) @(posedge aclk);
    strobe <= pulse;
    repeat (3) @(posedge aclk);
    strobe <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic raise_event(output logic seen);
    int n;
    seen = 1'b0;
    @(posedge aclk);
    req_n <= 1'b0;
    for (n = 0; n < 50 && !seen; n++) begin
      @(negedge aclk);
      seen = !ack_n;
    end
    @(posedge aclk);
    req_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bip_params.svh ***
`ifndef BIP_PARAMS_SVH
`define BIP_PARAMS_SVH

// ==========================================
// clock and timing
`define BIP_CLK_NS 10
`define BIP_SYS_HZ 100000000
`define BIP_CLK_OUT_HZ 5000000
`define BIP_CLK_HALF_CYC (`BIP_SYS_HZ / (2 * `BIP_CLK_OUT_HZ))
`define BIP_PULSE_MIN_NS 10
`define BIP_PULSE_MAX_NS 200
`define BIP_PULSE_MIN_CYC ((`BIP_PULSE_MIN_NS + `BIP_CLK_NS - 1) / `BIP_CLK_NS)
`define BIP_PULSE_MAX_CYC (`BIP_PULSE_MAX_NS / `BIP_CLK_NS)

// ==========================================
// widths
`define BIP_ADDR_W 8
`define BIP_DATA_W 32
`define BIP_BYTE_W 8
`define BIP_CNT_W 5
`define BIP_DIV_W 4
`define BIP_IRQ_W 3
`define BIP_STATUS_W 6
`define BIP_EVT_RD_W 2

// ==========================================
// register offsets
`define BIP_OFF_LED 8'h00
`define BIP_OFF_OUT 8'h04
`define BIP_OFF_IN 8'h08
`define BIP_OFF_STATUS 8'h0c
`define BIP_OFF_EVT 8'h10
`define BIP_OFF_PULSE 8'h14
`define BIP_OFF_IRQ_STAT 8'h18
`define BIP_OFF_IRQ_MASK 8'h1c

// ==========================================
// fields and reset values
`define BIP_LED_RST 8'h00
`define BIP_BIT_SUB_RESET 0
`define BIP_BIT_SUB_ANALYSE 1
`define BIP_BIT_PORT_RESET 2
`define BIP_EVT_WAIT_BIT 0
`define BIP_IRQ_CAPTURE 0
`define BIP_IRQ_EVENT 1
`define BIP_IRQ_FLAG 2
`define BIP_RESP_OKAY 2'b00
`define BIP_RESP_SLVERR 2'b10

`endif

// *** bip_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bip_params.svh"

module bip_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`BIP_BYTE_W-1:0] data_in,
  input wire logic output_enable,
  input wire logic strobe,
  input wire logic bypass,
  input wire logic request_n,
  input wire logic flag_n,
  bip_sync_if.src sync
);

  // ==========================================
  // two-stage synchronisers, third stage only for edges
  bip_pkg::bip_sync_t s;
  bip_pkg::bip_sync_t next_s;

  localparam bip_pkg::bip_sync_t SYNC_RST = '{req1_n: 1'b1, req2_n: 1'b1, flag1_n: 1'b1, flag2_n: 1'b1,
                                              flag3_n: 1'b1, default: '0};

  always_comb begin
    next_s = s;
    next_s.data1 = data_in;
    next_s.data2 = s.data1;
    next_s.oe1 = output_enable;
    next_s.oe2 = s.oe1;
    next_s.strobe1 = strobe;
    next_s.strobe2 = s.strobe1;
    next_s.strobe3 = s.strobe2;
    next_s.bypass1 = bypass;
    next_s.bypass2 = s.bypass1;
    next_s.req1_n = request_n;
    next_s.req2_n = s.req1_n;
    next_s.flag1_n = flag_n;
    next_s.flag2_n = s.flag1_n;
    next_s.flag3_n = s.flag2_n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= SYNC_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // data and strobe share the same delay, so data is settled at the edge
  assign sync.data_s = s.data2;
  assign sync.oe_s = s.oe2;
  assign sync.bypass_s = s.bypass2;
  assign sync.req_n_s = s.req2_n;
  assign sync.flag_n_s = s.flag2_n;
  assign sync.strobe_rise = s.strobe2 & ~s.strobe3;
  assign sync.flag_fall = s.flag3_n & ~s.flag2_n;

endmodule

`default_nettype wire

// *** bip_pkg.sv ***
`include "bip_params.svh"

package bip_pkg;

  typedef struct packed {
    logic awv;
    logic [`BIP_ADDR_W-1:0] awaddr;
    logic wv;
    logic [`BIP_DATA_W-1:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [`BIP_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [`BIP_BYTE_W-1:0] led;
    logic [`BIP_BYTE_W-1:0] outb;
    logic [`BIP_BYTE_W-1:0] inb;
    logic [`BIP_CNT_W-1:0] pulse_len;
    logic [`BIP_CNT_W-1:0] pulse_cnt;
    logic [`BIP_IRQ_W-1:0] irq_stat;
    logic [`BIP_IRQ_W-1:0] irq_mask;
    logic evt_wait;
    logic evt_ack;
    logic [`BIP_DIV_W-1:0] div_cnt;
    logic clk_q;
  } bip_state_t;

  typedef struct packed {
    logic [`BIP_BYTE_W-1:0] data1;
    logic [`BIP_BYTE_W-1:0] data2;
    logic oe1;
    logic oe2;
    logic strobe1;
    logic strobe2;
    logic strobe3;
    logic bypass1;
    logic bypass2;
    logic req1_n;
    logic req2_n;
    logic flag1_n;
    logic flag2_n;
    logic flag3_n;
  } bip_sync_t;

endpackage

// *** bip_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bip_params.svh"

// Functional notes
// - eight software-written latch bits drive socket pins
// - bits 0,1 give inverted subsystem reset, analyse
// - bit 2 is the socket reset line
// - eight shared data lines, one direction at once
// - enable high drives the outbound register out
// - enable low releases the data line drivers
// - inbound strobe rising edge captures data lines
// - outbound write pulses strobe low, bounded width
// - bypass low reads return live data lines
// - bypass high reads return inbound register
// - socket also carries events, clock, two single bits
// - ack stays low until request is released
// - port reset follows written latch bit value
// - external flag readable as a status bit
module bip_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`BIP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`BIP_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`BIP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`BIP_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [`BIP_BYTE_W-1:0] led_latch_bits,
  output logic subsys_reset_n,
  output logic subsys_analyse_n,
  output logic port_reset_latch,
  input wire logic [`BIP_BYTE_W-1:0] port_data_lines_in,
  output logic [`BIP_BYTE_W-1:0] port_data_lines_out,
  output logic port_data_lines_oe_n,
  input wire logic port_output_enable,
  input wire logic inbound_strobe,
  input wire logic inbound_bypass_select,
  output logic outbound_write_pulse,
  input wire logic event_request_n,
  output logic event_ack_n,
  output logic event_wait_n,
  input wire logic external_flag_n,
  output logic clock_out_n
);

  // ==========================================
  // helpers
  function automatic logic is_mapped(input logic [`BIP_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      `BIP_OFF_LED, `BIP_OFF_OUT, `BIP_OFF_IN, `BIP_OFF_STATUS,
      `BIP_OFF_EVT, `BIP_OFF_PULSE, `BIP_OFF_IRQ_STAT, `BIP_OFF_IRQ_MASK: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // keeps the pulse inside the allowed width window whatever software asks
  function automatic logic [`BIP_CNT_W-1:0] clamp_len(input logic [`BIP_CNT_W-1:0] v);
    logic [`BIP_CNT_W-1:0] r;
    r = v;
    if (v < `BIP_CNT_W'(`BIP_PULSE_MIN_CYC)) begin
      r = `BIP_CNT_W'(`BIP_PULSE_MIN_CYC);
    end else if (v > `BIP_CNT_W'(`BIP_PULSE_MAX_CYC)) begin
      r = `BIP_CNT_W'(`BIP_PULSE_MAX_CYC);
    end
    return r;
  endfunction

  // ==========================================
  // pin synchronisers
  bip_sync_if sync ();

  bip_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .data_in(port_data_lines_in),
    .output_enable(port_output_enable),
    .strobe(inbound_strobe),
    .bypass(inbound_bypass_select),
    .request_n(event_request_n),
    .flag_n(external_flag_n),
    .sync(sync.src)
  );

  // ==========================================
  // state
  localparam bip_pkg::bip_state_t ST_RST = '{pulse_len: `BIP_CNT_W'(`BIP_PULSE_MAX_CYC),
                                             led: `BIP_LED_RST, default: '0};

  bip_pkg::bip_state_t s;
  bip_pkg::bip_state_t next_s;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [`BIP_BYTE_W-1:0] read_port;
  logic [`BIP_IRQ_W-1:0] irq_set;

  // readies drop while frozen so no beat is taken that state cannot see
  assign s_axi_awready = ce & ~s.awv & ~s.bvalid;
  assign s_axi_wready = ce & ~s.wv & ~s.bvalid;
  assign s_axi_arready = ce & ~s.rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign do_write = s.awv & s.wv & ~s.bvalid;

  // live reads are two cycles old, the cost of the input synchronisers
  assign read_port = sync.bypass_s ? s.inb : sync.data_s;

  // ==========================================
  // next-state logic
  always_comb begin
    next_s = s;
    irq_set = '0;

    // ---- clock output divider
    if (s.div_cnt == `BIP_DIV_W'(`BIP_CLK_HALF_CYC - 1)) begin
      next_s.div_cnt = '0;
      next_s.clk_q = ~s.clk_q;
    end else begin
      next_s.div_cnt = s.div_cnt + `BIP_DIV_W'(1);
    end

    // ---- inbound capture
    if (sync.strobe_rise) begin
      next_s.inb = sync.data_s;
      irq_set[`BIP_IRQ_CAPTURE] = 1'b1;
    end
    if (sync.flag_fall) begin
      irq_set[`BIP_IRQ_FLAG] = 1'b1;
    end

    // ---- event handshake
    if (s.evt_ack) begin
      if (sync.req_n_s) begin
        next_s.evt_ack = 1'b0;
      end
    end else if (s.evt_wait && !sync.req_n_s) begin
      next_s.evt_ack = 1'b1;
      next_s.evt_wait = 1'b0;
      irq_set[`BIP_IRQ_EVENT] = 1'b1;
    end

    // ---- outbound pulse countdown
    if (s.pulse_cnt != '0) begin
      next_s.pulse_cnt = s.pulse_cnt - `BIP_CNT_W'(1);
    end

    // ---- write channel
    if (aw_take) begin
      next_s.awv = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      next_s.wv = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_s.awv = 1'b0;
      next_s.wv = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(s.awaddr) ? `BIP_RESP_OKAY : `BIP_RESP_SLVERR;
      // only lane 0 matters, every register is a byte or less
      if (s.wstrb0) begin
        unique case (s.awaddr)
          `BIP_OFF_LED: begin
            next_s.led = s.wdata[`BIP_BYTE_W-1:0];
          end
          `BIP_OFF_OUT: begin
            next_s.outb = s.wdata[`BIP_BYTE_W-1:0];
            next_s.pulse_cnt = clamp_len(s.pulse_len);
          end
          `BIP_OFF_EVT: begin
            if (s.wdata[`BIP_EVT_WAIT_BIT] && !s.evt_ack) begin
              next_s.evt_wait = 1'b1;
            end
          end
          `BIP_OFF_PULSE: begin
            next_s.pulse_len = clamp_len(s.wdata[`BIP_CNT_W-1:0]);
          end
          `BIP_OFF_IRQ_MASK: begin
            next_s.irq_mask = s.wdata[`BIP_IRQ_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // ---- read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = '0;
      // unmapped reads give zero data and an error response
      next_s.rresp = is_mapped(s_axi_araddr) ? `BIP_RESP_OKAY : `BIP_RESP_SLVERR;
      unique case (s_axi_araddr)
        `BIP_OFF_LED: begin
          next_s.rdata[`BIP_BYTE_W-1:0] = s.led;
        end
        `BIP_OFF_OUT: begin
          next_s.rdata[`BIP_BYTE_W-1:0] = s.outb;
        end
        `BIP_OFF_IN: begin
          next_s.rdata[`BIP_BYTE_W-1:0] = read_port;
        end
        `BIP_OFF_STATUS: begin
          next_s.rdata[`BIP_STATUS_W-1:0] = {s.evt_wait, s.evt_ack, ~sync.req_n_s, ~sync.flag_n_s,
                               sync.oe_s, sync.bypass_s};
        end
        `BIP_OFF_EVT: begin
          next_s.rdata[`BIP_EVT_RD_W-1:0] = {s.evt_ack, s.evt_wait};
        end
        `BIP_OFF_PULSE: begin
          next_s.rdata[`BIP_CNT_W-1:0] = s.pulse_len;
        end
        `BIP_OFF_IRQ_STAT: begin
          next_s.rdata[`BIP_IRQ_W-1:0] = s.irq_stat;
          next_s.irq_stat = '0;
        end
        `BIP_OFF_IRQ_MASK: begin
          next_s.rdata[`BIP_IRQ_W-1:0] = s.irq_mask;
        end
        default: begin
        end
      endcase
    end

    // an event in the clearing cycle survives the read-clear
    next_s.irq_stat = next_s.irq_stat | irq_set;
  end

  // ==========================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================
  // outputs
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign irq = |(s.irq_stat & s.irq_mask);

  assign led_latch_bits = s.led;
  assign subsys_reset_n = ~s.led[`BIP_BIT_SUB_RESET];
  assign subsys_analyse_n = ~s.led[`BIP_BIT_SUB_ANALYSE];
  assign port_reset_latch = s.led[`BIP_BIT_PORT_RESET];

  // direction follows the synchronised enable, two cycles behind the pin
  assign port_data_lines_out = s.outb;
  assign port_data_lines_oe_n = ~sync.oe_s;
  // a write during a running pulse restarts it, so pulses can merge
  assign outbound_write_pulse = (s.pulse_cnt == '0);

  assign event_ack_n = ~s.evt_ack;
  assign event_wait_n = ~s.evt_wait;
  assign clock_out_n = ~s.clk_q;

endmodule

`default_nettype wire

// *** bip_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bip_params.svh"
// ========
// port checker
module bip_port_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`BIP_BYTE_W-1:0] led_latch_bits,
  input wire logic subsys_reset_n,
  input wire logic subsys_analyse_n,
  input wire logic port_reset_latch,
  input wire logic [`BIP_BYTE_W-1:0] port_data_lines_out,
  input wire logic port_data_lines_oe_n,
  input wire logic port_output_enable,
  input wire logic outbound_write_pulse,
  input wire logic event_request_n,
  input wire logic event_ack_n,
  input wire logic clock_out_n
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence out_write; $fell(outbound_write_pulse); endsequence
  sequence ack_granted; !event_ack_n && !event_request_n; endsequence
  latch_inv_a:
    assert property (subsys_reset_n == !led_latch_bits[0] && subsys_analyse_n == !led_latch_bits[1])
    else $error("subsystem lines not inverse of latch");
  port_reset_a:
    assert property (port_reset_latch == led_latch_bits[2])
    else $error("port reset not latch bit");
  // enable passes two sync flops; skip edges that still see reset
  drive_dir_a:
    assert property ($past(aresetn, 2) |-> port_data_lines_oe_n == !$past(port_output_enable, 2))
    else $error("data drive direction wrong");
  // reset itself changes outputs, so the first edge after it is skipped
  out_hold_a:
    assert property ($past(aresetn) && $changed(port_data_lines_out) |-> out_write)
    else $error("outbound data changed without write");
  pulse_width_a:
    assert property (out_write |-> ##[1:20] outbound_write_pulse)
    else $error("write pulse too long");
  ack_hold_a:
    assert property (ack_granted |=> !event_ack_n)
    else $error("ack left before request release");
  ack_release_a:
    assert property ($rose(event_request_n) && !event_ack_n |-> ##[1:4] event_ack_n)
    else $error("ack not released");
  clk_period_a:
    assert property ($past(aresetn) && $changed(clock_out_n) |=>
      $stable(clock_out_n)[*8] ##1 $stable(clock_out_n) ##1 $changed(clock_out_n))
    else $error("clock out period wrong");
endmodule

bind bip_port bip_port_props u_props (.*);
`default_nettype wire

// *** bip_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bip_params.svh"

interface bip_sync_if;
  logic [`BIP_BYTE_W-1:0] data_s;
  logic oe_s;
  logic bypass_s;
  logic req_n_s;
  logic flag_n_s;
  logic strobe_rise;
  logic flag_fall;

  modport src (
    output data_s,
    output oe_s,
    output bypass_s,
    output req_n_s,
    output flag_n_s,
    output strobe_rise,
    output flag_fall
  );

  modport dst (
    input data_s,
    input oe_s,
    input bypass_s,
    input req_n_s,
    input flag_n_s,
    input strobe_rise,
    input flag_fall
  );
endinterface

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bip_params.svh"
// ========
// bench
module tb_top;
  localparam logic [1:0] ok = `BIP_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] led_latch_bits, port_data_lines_in, port_data_lines_out;
  logic subsys_reset_n, subsys_analyse_n, port_reset_latch, port_data_lines_oe_n, port_output_enable;
  logic inbound_strobe, inbound_bypass_select, outbound_write_pulse, event_request_n, event_ack_n;
  logic event_wait_n, external_flag_n, clock_out_n;
  int error_cnt = 0;
  int checks = 0;
  int low_cnt = 0;
  bip_port dut (.ce(1'b1), .*);
  bip_ext_model ext (
    .aclk, .data_out(port_data_lines_out), .oe_n(port_data_lines_oe_n), .ack_n(event_ack_n),
    .data_in(port_data_lines_in), .out_en(port_output_enable), .strobe(inbound_strobe),
    .bypass(inbound_bypass_select), .req_n(event_request_n), .flag_n(external_flag_n)
  );
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (!outbound_write_pulse) begin
      low_cnt <= low_cnt + 1;
    end
  end
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n > 200) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    int n;
    b_hs = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; !b_hs; n++) begin
      @(negedge aclk);
      guard(n);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    int n;
    r_hs = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; !r_hs; n++) begin
      @(negedge aclk);
      guard(n);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(r, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp);
    chk(r, er);
  endtask
  task automatic t_reset();
    logic c;
    chk(led_latch_bits, 32'h0);
    chk({subsys_analyse_n, subsys_reset_n}, 32'h3);
    chk({port_data_lines_oe_n, outbound_write_pulse, event_ack_n}, 32'h7);
    rdc(`BIP_OFF_PULSE, 32'h14, ok);
    rdc(`BIP_OFF_IRQ_MASK, 32'h0, ok);
    wrc(8'h24, 32'hff, `BIP_RESP_SLVERR);
    rdc(8'h20, 32'h0, `BIP_RESP_SLVERR);
    rdc(`BIP_OFF_LED, 32'h0, ok);
    // sampled away from the edge that toggles it
    @(negedge aclk);
    c = ~clock_out_n;
    repeat (10) @(negedge aclk);
    chk(clock_out_n, c);
  endtask
  task automatic t_led();
    logic [7:0] pat [3] = '{8'h05, 8'h02, 8'hfa};
    foreach (pat[i]) begin
      wrc(`BIP_OFF_LED, {24'h0, pat[i]}, ok);
      chk(led_latch_bits, pat[i]);
      chk({subsys_analyse_n, subsys_reset_n}, 2'(~pat[i][1:0]));
      chk(port_reset_latch, pat[i][2]);
      rdc(`BIP_OFF_LED, {24'h0, pat[i]}, ok);
    end
  endtask
  // lengths outside 1..20 are clamped, so both ends are probed
  task automatic t_out();
    logic [7:0] len [4] = '{8'h00, 8'h01, 8'h14, 8'h19};
    logic [7:0] expl [4] = '{8'h01, 8'h01, 8'h14, 8'h14};
    int base;
    foreach (len[i]) begin
      wrc(`BIP_OFF_PULSE, {24'h0, len[i]}, ok);
      rdc(`BIP_OFF_PULSE, {24'h0, expl[i]}, ok);
      base = low_cnt;
      wrc(`BIP_OFF_OUT, {24'h0, len[i] ^ 8'h96}, ok);
      cyc(24);
      chk(low_cnt - base, expl[i]);
      chk(port_data_lines_out, len[i] ^ 8'h96);
    end
    ext.set_pins(1'b1, 1'b1, 1'b1);
    cyc(4);
    chk(port_data_lines_oe_n, 1'b0);
    chk(port_data_lines_in, 8'h19 ^ 8'h96);
    ext.set_pins(1'b0, 1'b1, 1'b1);
    cyc(4);
    chk(port_data_lines_oe_n, 1'b1);
  endtask
  task automatic t_in();
    ext.send_byte(8'h3c, 1'b1);
    rdc(`BIP_OFF_IN, 32'h3c, ok);
    ext.send_byte(8'h5a, 1'b0);
    rdc(`BIP_OFF_IN, 32'h3c, ok);
    ext.set_pins(1'b0, 1'b0, 1'b1);
    cyc(4);
    rdc(`BIP_OFF_IN, 32'h5a, ok);
    chk(irq, 1'b0);
    wrc(`BIP_OFF_IRQ_MASK, 32'h7, ok);
    cyc(2);
    chk(irq, 1'b1);
    rdc(`BIP_OFF_IRQ_STAT, 32'h1, ok);
    cyc(2);
    chk(irq, 1'b0);
  endtask
  task automatic t_flag();
    ext.set_pins(1'b0, 1'b0, 1'b0);
    cyc(4);
    rdc(`BIP_OFF_STATUS, 32'h4, ok);
    chk(irq, 1'b1);
    rdc(`BIP_OFF_IRQ_STAT, 32'h4, ok);
    ext.set_pins(1'b0, 1'b0, 1'b1);
    cyc(4);
    rdc(`BIP_OFF_STATUS, 32'h0, ok);
  endtask
  task automatic t_event();
    logic seen;
    wrc(`BIP_OFF_EVT, 32'h1, ok);
    cyc(2);
    chk(event_wait_n, 1'b0);
    ext.raise_event(seen);
    chk(seen, 1'b1);
    cyc(6);
    chk({event_wait_n, event_ack_n}, 32'h3);
    rdc(`BIP_OFF_IRQ_STAT, 32'h2, ok);
  endtask
  initial begin
    cyc(16);
    aresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_led();
    t_out();
    t_in();
    t_flag();
    t_event();
    print_verdict();
  end
  initial begin
    cyc(40000);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
